// *** include/timer0_pkg.sv ***
/*
  Constants, register map and carrier types of the 8-bit timer with a
  prescaler shared with the watchdog. Assumes a 250 MHz core clock from
  which four phases make one instruction cycle.
*/
// How it works
// - Timer mode, no prescaler: count each cycle
// - Count write blocks counting two cycles
// - Counter mode counts selected pin edges
// - Bit 5 picks pin or instruction clock
// - Bit 4 set counts falling, clear rising
// - Bit 3 gives prescaler to watchdog or timer
// - Rate field: timer 1:2..1:256, watchdog half
// - Prescaler hidden; count write clears it when it sits with the timer
// - Watchdog clear also clears its prescaler
// - Wrap from all-ones sets overflow flag
// - Software or a warm reset clears the overflow flag
// - Request only when flag and enable set
// - Sleep freezes the count
// - Pin events sampled on phases two, four
// - Configuration resets to all ones
// - Count kept through warm resets
`default_nettype none

package timer0_pkg;

  // ==========================================================
  // Register map
  localparam logic [1:0] CONFIG_ADDR = 2'h0;
  localparam logic [1:0] INTCTL_ADDR = 2'h1;
  localparam logic [1:0] COUNT_ADDR  = 2'h2;

  localparam logic [7:0] CONFIG_RESET = 8'hff;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET  = 8'h00;

  // Bit positions inside the interrupt control register.
  localparam int OVF_ENABLE_BIT = 5;
  localparam int OVF_FLAG_BIT   = 2;

  // ==========================================================
  // Timing
  localparam int         PHASES_PER_CYCLE = 4;
  localparam logic [1:0] INHIBIT_CYCLES   = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } phase_e;

  typedef struct packed {
    logic       pullup_off;
    logic       int_rising;
    logic       clock_source_select;
    logic       source_edge_select;
    logic       prescaler_assignment;
    logic [2:0] prescale_rate_field;
  } config_s;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  // Mask of prescaler bits that must all be one for a tick out.
  function automatic logic [7:0] rate_mask(input logic [2:0] rate,
                                           input logic       watchdog);
    logic [8:0] full;
    full = 9'h001 << rate;
    if (!watchdog) begin
      full = full << 1;
    end
    rate_mask = full[7:0] - 8'h01;
  endfunction

endpackage

`default_nettype wire

// *** logic/pin_edge_sync.sv ***
/*
  Two-flop synchroniser for the external count pin with an edge
  detector behind it. Assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_edge_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic ce,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic falling,
  // Result
  output logic      edge_pulse
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // ==========================================================
  // Synchroniser
  // The first flop feeds only the second; the detector looks later.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce) begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign edge_pulse = falling ? (prev_q & ~sync_q)
                              : (~prev_q & sync_q);

endmodule

`default_nettype wire

// *** logic/timer0_shared_prescaler.sv ***
/*
  Eight-bit timer and counter with a prescaler shared with the
  watchdog, plus its configuration, interrupt control and count
  registers on a plain register port. Assumes the register master
  and the watchdog run on clock, and the count pin is asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none

module timer0_shared_prescaler
  import timer0_pkg::*;
#(
  parameter int PRES_W = 8
) (
  // Clock and reset
  input  wire logic     clock,
  input  wire logic     reset_n,
  input  wire logic     ce,
  input  wire logic     warm_reset,
  // Register port
  input  wire bus_req_s bus_req,
  output logic [7:0]    rd_data,
  // Core status
  input  wire logic     sleep,
  input  wire logic     watchdog_clear_instruction,
  // Count pin
  input  wire logic     external_count_pin,
  // Watchdog path
  input  wire logic     watchdog_tick,
  output logic          watchdog_scaled_tick,
  // Interrupt request
  output logic          overflow_irq
);

  // ==========================================================
  // Declarations
  config_s           config_q;
  logic [7:0]        intctl_q;
  logic [7:0]        count_q;
  logic [7:0]        rd_data_q;
  logic [PRES_W-1:0] pres_q;
  logic [1:0]        inhibit_q;
  logic              pend_q;
  phase_e            phase_q;

  logic       wr_config;
  logic       wr_intctl;
  logic       wr_count;
  logic       wd_side;
  logic       ext_edge;
  logic       raw_evt;
  logic       pres_evt;
  logic       pres_hold;
  logic       pres_done;
  logic       tmr_src;
  logic       sample_ph;
  logic       count_inc;
  logic [7:0] mask;

  assign wr_config = bus_req.wr && bus_req.addr == CONFIG_ADDR;
  assign wr_intctl = bus_req.wr && bus_req.addr == INTCTL_ADDR;
  assign wr_count  = bus_req.wr && bus_req.addr == COUNT_ADDR;
  assign wd_side   = config_q.prescaler_assignment;

  // ==========================================================
  // Instruction phases
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= PH_ONE;
    end else if (ce) begin
      unique case (phase_q)
        PH_ONE:   phase_q <= PH_TWO;
        PH_TWO:   phase_q <= PH_THREE;
        PH_THREE: phase_q <= PH_FOUR;
        PH_FOUR:  phase_q <= PH_ONE;
      endcase
    end
  end

  // ==========================================================
  // Event sources
  pin_edge_sync u_pin_sync (
    .clock      (clock),
    .reset_n    (reset_n),
    .ce         (ce),
    .pin        (external_count_pin),
    .falling    (config_q.source_edge_select),
    .edge_pulse (ext_edge)
  );

  assign raw_evt = config_q.clock_source_select ? ext_edge
                                                : phase_q == PH_FOUR;
  assign pres_evt  = wd_side ? watchdog_tick : raw_evt;
  // The timer's half of the prescaler freezes with the count.
  assign pres_hold = sleep && !wd_side;
  assign mask      = rate_mask(config_q.prescale_rate_field, wd_side);
  assign pres_done = pres_evt && !pres_hold &&
                     ((pres_q[7:0] & mask) == mask);
  // Timer undivided only when the prescaler sits with the watchdog.
  assign tmr_src = wd_side ? raw_evt : pres_done;
  assign watchdog_scaled_tick = wd_side ? pres_done : watchdog_tick;

  // ==========================================================
  // Prescaler
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pres_q <= '0;
    end else if (ce) begin
      if (wr_count && !wd_side) begin
        pres_q <= '0;
      end else if (watchdog_clear_instruction && wd_side) begin
        pres_q <= '0;
      end else if (pres_evt && !pres_hold) begin
        pres_q <= pres_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Counter-mode synchronisation
  // Pin ticks wait for the next phase two or four, as the core would
  // see them; a tick landing on a sample phase is taken at once.
  assign sample_ph = phase_q == PH_TWO || phase_q == PH_FOUR;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (ce) begin
      if (!config_q.clock_source_select || sample_ph) begin
        pend_q <= 1'b0;
      end else if (tmr_src) begin
        pend_q <= 1'b1;
      end
    end
  end

  always_comb begin
    if (config_q.clock_source_select) begin
      count_inc = sample_ph && (pend_q || tmr_src);
    end else begin
      count_inc = tmr_src;
    end
    if (sleep || inhibit_q != 2'h0 || warm_reset) begin
      count_inc = 1'b0;
    end
  end

  // ==========================================================
  // Write inhibit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      inhibit_q <= 2'h0;
    end else if (ce) begin
      if (wr_count) begin
        inhibit_q <= INHIBIT_CYCLES;
      end else if (phase_q == PH_FOUR && inhibit_q != 2'h0) begin
        inhibit_q <= inhibit_q - 2'h1;
      end
    end
  end

  // ==========================================================
  // Count register
  // Only power-on clears it; a warm reset leaves it alone.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= COUNT_RESET;
    end else if (ce) begin
      if (wr_count) begin
        count_q <= bus_req.wdata;
      end else if (count_inc) begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // Configuration register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= config_s'(CONFIG_RESET);
    end else if (ce) begin
      if (warm_reset) begin
        config_q <= config_s'(CONFIG_RESET);
      end else if (wr_config) begin
        config_q <= config_s'(bus_req.wdata);
      end
    end
  end

  // ==========================================================
  // Interrupt control register
  // A wrap in the same cycle as a software clear leaves the flag set.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      intctl_q <= INTCTL_RESET;
    end else if (ce) begin
      if (warm_reset) begin
        intctl_q <= INTCTL_RESET;
      end else begin
        if (wr_intctl) begin
          intctl_q <= bus_req.wdata;
        end
        // A count write in the wrap cycle wins, so no wrap happens.
        if (count_inc && !wr_count && count_q == 8'hff) begin
          intctl_q[OVF_FLAG_BIT] <= 1'b1;
        end
      end
    end
  end

  assign overflow_irq = intctl_q[OVF_FLAG_BIT] &&
                        intctl_q[OVF_ENABLE_BIT];

  // ==========================================================
  // Read data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else if (ce) begin
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          CONFIG_ADDR: rd_data_q <= config_q;
          INTCTL_ADDR: rd_data_q <= intctl_q;
          COUNT_ADDR:  rd_data_q <= count_q;
          default:     rd_data_q <= 8'h00;
        endcase
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

  assign rd_data = rd_data_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_count_write;
    ce && wr_count;
  endsequence

  sequence s_timer_tick;
    ce && !config_q.clock_source_select && wd_side && !sleep &&
    phase_q == PH_FOUR && inhibit_q == 2'h0 && !wr_count && !warm_reset;
  endsequence

  a_timer_step: assert property (
    s_timer_tick |=> count_q == $past(count_q) + 8'h01)
    else $error("Count did not step on an undivided timer cycle.");

  a_write_inhibit: assert property (
    s_count_write |=> inhibit_q == 2'h2 && count_q == $past(bus_req.wdata))
    else $error("Count write did not load and start the inhibit.");

  a_inhibit_hold: assert property (
    (ce && inhibit_q != 2'h0 && !wr_count) |=> count_q == $past(count_q))
    else $error("Count moved while inhibited.");

  a_edge_phase: assert property (
    (ce && config_q.clock_source_select && count_inc) |->
      (phase_q == PH_TWO || phase_q == PH_FOUR))
    else $error("Pin event counted outside phases two and four.");

  a_overflow_set: assert property (
    (ce && count_inc && !wr_count && count_q == 8'hff && !warm_reset)
      |=> intctl_q[OVF_FLAG_BIT] && count_q == 8'h00)
    else $error("Wrap did not set the overflow flag.");

  a_flag_sticky: assert property (
    (intctl_q[OVF_FLAG_BIT] && !(ce && (wr_intctl || warm_reset)))
      |=> intctl_q[OVF_FLAG_BIT])
    else $error("Overflow flag cleared without software.");

  a_irq_gate: assert property (
    (ce && wr_intctl && !warm_reset && !bus_req.wdata[OVF_ENABLE_BIT])
      |=> !overflow_irq)
    else $error("Interrupt request with the enable clear.");

  a_irq_raise: assert property (
    (ce && count_inc && count_q == 8'hff && !wr_count && !wr_intctl &&
     intctl_q[OVF_ENABLE_BIT]) |=> overflow_irq)
    else $error("No interrupt request after an enabled wrap.");

  a_sleep_hold: assert property (
    (ce && sleep && !wr_count)[*2] |=> count_q == $past(count_q, 2))
    else $error("Count moved during sleep.");

  a_pres_write: assert property (
    (ce && wr_count && !wd_side) |=> pres_q == '0)
    else $error("Count write did not clear the prescaler.");

  a_pres_wdclr: assert property (
    (ce && watchdog_clear_instruction && wd_side && !wr_count)
      |=> pres_q == '0)
    else $error("Watchdog clear did not clear the prescaler.");

  a_warm_keep: assert property (
    (ce && warm_reset && !wr_count) |=>
      config_q == config_s'(CONFIG_RESET) && count_q == $past(count_q))
    else $error("Warm reset lost the count or missed the config.");

  // A pin event seen off a sample phase must still count one cycle on.
  sequence s_pin_late;
    ce && config_q.clock_source_select && !sample_ph && tmr_src &&
    inhibit_q == 2'h0 && !sleep && !wr_count && !warm_reset;
  endsequence

  sequence s_next_open;
    ce && config_q.clock_source_select && !sleep && !wr_count &&
    !warm_reset;
  endsequence

  a_pin_pending: assert property (
    s_pin_late ##1 s_next_open |=> count_q == $past(count_q) + 8'h01)
    else $error("Pin event off a sample phase was lost.");

endmodule

`default_nettype wire

// *** sim/count_source_model.sv ***
/*
  Source for the external count pin: makes a given number of level
  changes, each level held for a chosen number of clocks.
  Assumes the bench calls toggle and that the pin has no pull.
*/
`timescale 1ns/1ns
`default_nettype none

module count_source_model (
  // Clock
  input  wire logic clock,
  // Count pin
  output var logic  pin
);
  // ==========================================================
  // Level changes
  // Changes land on the falling clock edge, so the pin is never in
  // step with the sampling edge, as a real outside source would be.
  task automatic toggle(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(negedge clock);
      pin <= ~pin;
    end
    repeat (hold) @(negedge clock);
  endtask

  initial begin
    pin = 1'b0;
  end
endmodule

`default_nettype wire

// *** sim/timer0_shared_prescaler_tb_top.sv ***
/*
  Self-checking bench for the shared-prescaler timer: register port,
  sleep, warm reset, watchdog inputs, and a source on the count pin.
  Assumes ce stays high except in its own freeze test.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); \
  end \
end

module timer0_shared_prescaler_tb_top import timer0_pkg::*;;
  // ==========================================================
  // Signals
  logic       clock = 1'b0;
  logic       reset_n = 1'b0;
  logic       ce = 1'b1;
  logic       warm_reset = 1'b0;
  logic       sleep = 1'b0;
  logic       wd_clear = 1'b0;
  logic       wd_tick = 1'b0;
  bus_req_s   bus_req = '0;
  logic [7:0] rd_data;
  logic       pin;
  logic       scaled_tick;
  logic       irq;
  int         failures = 0;
  int         samples_checked = 0;
  int         ne = 0;
  int         hits;
  logic [7:0] a;
  logic [7:0] b;

  always #2 clock = ~clock;

  timer0_shared_prescaler #(.PRES_W(8)) dut (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .warm_reset(warm_reset),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .sleep(sleep),
    .watchdog_clear_instruction(wd_clear),
    .external_count_pin(pin),
    .watchdog_tick(wd_tick),
    .watchdog_scaled_tick(scaled_tick),
    .overflow_irq(irq)
  );

  count_source_model src (
    .clock(clock),
    .pin(pin)
  );

  // ==========================================================
  // Tasks
  // Edges are counted so that write timing can be set against the
  // instruction cycle phase.
  task automatic step(input int n = 1);
    repeat (n) begin
      @(posedge clock);
      ne++;
    end
  endtask

  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    bus_req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    step();
    bus_req <= '0;
    step();
  endtask

  task automatic rd(input logic [1:0] ad, output logic [7:0] v);
    bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    step();
    bus_req <= '0;
    #1 v = rd_data;
    step();
  endtask

  task automatic rdc(input logic [1:0] ad, input logic [7:0] e,
                     input string nm);
    logic [7:0] v;
    rd(ad, v);
    `CHK(nm, v, e)
  endtask

  task automatic irq_is(input logic e);
    #1;
    `CHK("irq", irq, e)
    step();
  endtask

  task automatic wd(input int n, output int h);
    h = 0;
    repeat (n) begin
      wd_tick <= 1'b1;
      #1 h += (scaled_tick === 1'b1);
      step();
      wd_tick <= 1'b0;
      step();
    end
  endtask

  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    finish_test();
  end

  // ==========================================================
  // Sequence
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rdc(CONFIG_ADDR, 8'hff, "config");
    rdc(INTCTL_ADDR, 8'h00, "intctl");
    rdc(COUNT_ADDR, 8'h00, "count");
    wr(2'h3, 8'h5a);
    rdc(2'h3, 8'h00, "unmapped");
    done("reset");
    // Write lands mid-cycle so a one-edge phase slip gives one answer.
    wr(CONFIG_ADDR, 8'h08);
    while (ne % 4 != 1) step();
    wr(COUNT_ADDR, 8'h10);
    step(38);
    rdc(COUNT_ADDR, 8'h18, "inhibit");
    done("inhibit");
    sleep <= 1'b1;
    wr(COUNT_ADDR, 8'h5a);
    step(40);
    warm_reset <= 1'b1;
    step();
    warm_reset <= 1'b0;
    rdc(COUNT_ADDR, 8'h5a, "count warm");
    rdc(CONFIG_ADDR, 8'hff, "config warm");
    done("warm reset");
    sleep <= 1'b0;
    wr(CONFIG_ADDR, 8'h08);
    wr(INTCTL_ADDR, 8'h20);
    wr(COUNT_ADDR, 8'hfe);
    step(40);
    rdc(INTCTL_ADDR, 8'h24, "flag");
    irq_is(1'b1);
    sleep <= 1'b1;
    wr(INTCTL_ADDR, 8'h04);
    irq_is(1'b0);
    step(100);
    rdc(INTCTL_ADDR, 8'h04, "flag kept");
    wr(INTCTL_ADDR, 8'h20);
    rdc(INTCTL_ADDR, 8'h20, "flag clear");
    irq_is(1'b0);
    done("overflow");
    sleep <= 1'b0;
    wr(CONFIG_ADDR, 8'h28);
    wr(COUNT_ADDR, 8'h00);
    step(12);
    src.toggle(5, 8);
    step();
    rdc(COUNT_ADDR, 8'h03, "rising");
    wr(CONFIG_ADDR, 8'h38);
    step(8);
    wr(COUNT_ADDR, 8'h00);
    step(12);
    src.toggle(3, 20);
    step();
    rdc(COUNT_ADDR, 8'h02, "falling");
    // Two bursts an odd number of clocks apart put one falling edge
    // off the sample phases, so the pending path must carry it.
    src.toggle(2, 9);
    step();
    src.toggle(2, 9);
    step();
    rdc(COUNT_ADDR, 8'h04, "late edge");
    done("pin");
    for (int i = 0; i < 9; i++) begin
      wr(CONFIG_ADDR, i == 0 ? 8'h08 : 8'(i - 1));
      step(8);
      rd(COUNT_ADDR, a);
      step((8 << i) - 2);
      rd(COUNT_ADDR, b);
      `CHK("rate", 8'(b - a), 8'h02)
    end
    wr(CONFIG_ADDR, 8'h07);
    step(500);
    wr(COUNT_ADDR, 8'h00);
    step(998);
    rdc(COUNT_ADDR, 8'h00, "pres clear");
    step(98);
    rdc(COUNT_ADDR, 8'h01, "first tick");
    done("timer rates");
    for (int r = 0; r < 8; r++) begin
      wr(CONFIG_ADDR, 8'h08 | 8'(r));
      wd(2, hits);
      wd_clear <= 1'b1;
      step();
      wd_clear <= 1'b0;
      step();
      wd((1 << r) - 1, hits);
      `CHK("wd early", hits, 0)
      wd(1, hits);
      `CHK("wd ratio", hits, 1)
    end
    wr(CONFIG_ADDR, 8'h00);
    wd(3, hits);
    `CHK("wd bypass", hits, 3)
    done("watchdog");
    // Eight enabled clocks span two instruction cycles at any phase.
    wr(CONFIG_ADDR, 8'h08);
    rd(COUNT_ADDR, a);
    ce <= 1'b0;
    step(40);
    ce <= 1'b1;
    step(6);
    rd(COUNT_ADDR, b);
    `CHK("ce hold", 8'(b - a), 8'h02)
    done("clock enable");
    finish_test();
  end
endmodule

`default_nettype wire
